// [src/spa_pkg.sv]
// ****************************************************************
// Shared constants and types of the second serial port.
// ****************************************************************
package spa_pkg;

   localparam int          SFR_AW          = 8;
   localparam int          SFR_DW          = 8;

   // ****************************************************************
   // Register addresses and reset values.
   // ****************************************************************
   localparam logic [7:0]  ADDR_STATION    = 8'haa;
   localparam logic [7:0]  ADDR_MASK       = 8'hba;
   localparam logic [7:0]  ADDR_CONTROL    = 8'hc0;
   localparam logic [7:0]  ADDR_BUFFER     = 8'hc1;
   localparam logic [7:0]  RESET_BYTE      = 8'h00;
   localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

   // ****************************************************************
   // Control register field positions.
   // ****************************************************************
   localparam int          CTL_MODE_HI     = 7;
   localparam int          CTL_MODE_LO     = 6;
   localparam int          CTL_MULTIPROC   = 5;
   localparam int          CTL_RX_ENABLE   = 4;
   localparam int          CTL_TX_NINTH    = 3;
   localparam int          CTL_RX_NINTH    = 2;
   localparam int          CTL_TX_DONE     = 1;
   localparam int          CTL_RX_DONE     = 0;

   // ****************************************************************
   // Modes, frame lengths and timing counts.
   // ****************************************************************
   localparam logic [1:0]  MODE_SYNC       = 2'h0;
   localparam logic [1:0]  MODE_ASYNC10    = 2'h1;
   localparam logic [3:0]  TX_BITS_10      = 4'ha;
   localparam logic [3:0]  TX_BITS_11      = 4'hb;
   localparam logic [3:0]  SYNC_BITS       = 4'h8;
   localparam logic [3:0]  RX_BITS_10      = 4'h9;
   localparam logic [3:0]  RX_BITS_11      = 4'ha;
   localparam logic [3:0]  STOP_LEFT       = 4'h1;
   localparam logic [3:0]  MID_TICK        = 4'h7;
   localparam logic [3:0]  LAST_TICK       = 4'hf;
   localparam int          OVERSAMPLE      = 16;
   localparam int          MODE2_BIT_CLKS  = 64;
   localparam int          MODE2_TICK_DIV  = MODE2_BIT_CLKS / OVERSAMPLE;
   localparam int          MODE0_CLKS_SLOW = 12;
   localparam int          MODE0_CLKS_FAST = 4;

   typedef enum logic [1:0] {TX_IDLE, TX_ASYNC, TX_SYNC} spa_tx_st_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_SYNC} spa_rx_st_t;

endpackage

// [src/spa_tick_if.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Bit timing handshake between the port core and its tick source.
// ****************************************************************
interface spa_tick_if;
   logic [1:0] mode;
   logic       multiproc_select;
   logic       t1_ovf;
   logic       sample_tick;
   logic       shift_tick;

   modport gen  (input mode, multiproc_select, t1_ovf, output sample_tick, shift_tick);
   modport core (output mode, multiproc_select, t1_ovf, input sample_tick, shift_tick);
endinterface
`default_nettype wire

// [src/spa_tick_gen.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Oversample tick for the framed modes, half-bit tick for mode 0.
// ****************************************************************
module spa_tick_gen
   import spa_pkg::*;
#(
   parameter int MODE2_DIV = spa_pkg::MODE2_TICK_DIV,
   parameter int M0_SLOW   = spa_pkg::MODE0_CLKS_SLOW,
   parameter int M0_FAST   = spa_pkg::MODE0_CLKS_FAST
)(
   // Clock and reset
   input wire logic   CLK,
   input wire logic   RESETN,
   // Timing link to the core
   spa_tick_if.gen    tk
);
   if (MODE2_DIV < 1 || MODE2_DIV > 255 || M0_SLOW < 2 || M0_FAST < 2 || M0_SLOW > 510
       || M0_FAST > 510)
   begin : g_chk
      $error("spa_tick_gen: divider out of range");
   end

   localparam logic [7:0] M2_LAST   = 8'(MODE2_DIV - 1);
   localparam logic [7:0] SLOW_LAST = 8'(M0_SLOW / 2 - 1);
   localparam logic [7:0] FAST_LAST = 8'(M0_FAST / 2 - 1);

   typedef struct packed {
      logic [7:0] div_cnt;
      logic [7:0] half_cnt;
      logic       sample_tick;
      logic       shift_tick;
   } spa_tick_state_t;

   spa_tick_state_t s_reg;
   spa_tick_state_t s_next;
   logic [7:0]      half_last;

   always_comb
   begin
      s_next = s_reg;
      // In mode 0 the multiprocessor bit picks the fast or the slow bit period.
      half_last = tk.multiproc_select ? FAST_LAST : SLOW_LAST;
      s_next.sample_tick = 1'b0;
      s_next.shift_tick  = 1'b0;
      if (s_reg.div_cnt >= M2_LAST)
      begin
         s_next.div_cnt = 8'h00;
      end
      else
      begin
         s_next.div_cnt = s_reg.div_cnt + 8'h01;
      end
      if (s_reg.half_cnt >= half_last)
      begin
         s_next.half_cnt   = 8'h00;
         s_next.shift_tick = 1'b1;
      end
      else
      begin
         s_next.half_cnt = s_reg.half_cnt + 8'h01;
      end
      // Modes 1 and 3 follow timer 1, mode 2 the fixed clock divider.
      if (tk.mode[0])
      begin
         s_next.sample_tick = tk.t1_ovf;
      end
      else
      begin
         s_next.sample_tick = (s_reg.div_cnt >= M2_LAST);
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign tk.sample_tick = s_reg.sample_tick;
   assign tk.shift_tick  = s_reg.shift_tick;

endmodule
`default_nettype wire

// [src/spa_serial_port1.sv]
`timescale 1ns/1ps
`default_nettype none
module spa_serial_port1
(
   // Clock and reset
   input  wire logic                      CLK,
   input  wire logic                      RESETN,
   // Special function register port
   input  wire logic [spa_pkg::SFR_AW-1:0] SFR_ADDR,
   input  wire logic                      SFR_WR,
   input  wire logic                      SFR_RD,
   input  wire logic [spa_pkg::SFR_DW-1:0] SFR_WDATA,
   output var  logic [spa_pkg::SFR_DW-1:0] SFR_RDATA,
   // Control bits held elsewhere in the core, and the timer 1 overflow
   input  wire logic                      FRAME_ERR_VIEW_SELECT,
   input  wire logic                      PORT1_IRQ_ENABLE,
   input  wire logic                      T1_OVF,
   // Serial pins
   output var  logic                      TXD,
   input  wire logic                      RXD_IN,
   output var  logic                      RXD_OUT,
   output var  logic                      RXD_OE,
   // Status
   output var  logic                      SERIAL1_IRQ,
   output var  logic                      TX_ACTIVITY_STATUS
);
   import spa_pkg::*;

   typedef struct packed {
      logic [7:0] mask;
      logic [7:0] saddr;
      logic       mode_hi;
      logic       mode_lo;
      logic       sm2;
      logic       ren;
      logic       tb8;
      logic       rb8;
      logic       ti;
      logic       ri;
      logic       fe;
      logic [7:0] rbuf;
      logic [7:0] rdata;
      spa_tx_st_t tx_st;
      logic [10:0] tx_sh;
      logic [3:0] tx_bits;
      logic [3:0] tx_cnt;
      logic       tx_ph;
      spa_rx_st_t rx_st;
      logic [8:0] rx_sh;
      logic [3:0] rx_bits;
      logic [3:0] rx_cnt;
      logic       rx_ph;
      logic       rx_prev;
      logic       irq;
      logic       txd;
      logic       rxd_out;
      logic       rxd_oe;
      logic       txact;
   } spa_state_t;

   spa_state_t s_reg;
   spa_state_t s_next;
   spa_tick_if tk ();

   logic [1:0] mode;
   logic       wr_ctl;
   logic       wr_buf;
   logic       rx_fin;
   logic       rx_stop;
   logic [7:0] rx_byte;
   logic       rx_ninth;
   logic       addr_match;
   logic       rx_accept;

   // ****************************************************************
   // Tick source.
   // ****************************************************************
   assign tk.mode             = mode;
   assign tk.multiproc_select = s_reg.sm2;
   assign tk.t1_ovf           = T1_OVF;

   spa_tick_gen u_tick (
      .CLK    (CLK),
      .RESETN (RESETN),
      .tk     (tk)
   );

   // ****************************************************************
   // Receive decision, shared by the state update and the checks.
   // ****************************************************************
   assign mode     = {s_reg.mode_hi, s_reg.mode_lo};
   assign wr_ctl   = SFR_WR && (SFR_ADDR == ADDR_CONTROL);
   assign wr_buf   = SFR_WR && (SFR_ADDR == ADDR_BUFFER);
   assign rx_fin   = (s_reg.rx_st == RX_DATA) && tk.sample_tick && s_reg.ren
                     && (s_reg.rx_cnt == LAST_TICK) && (s_reg.rx_bits == STOP_LEFT);
   assign rx_stop  = RXD_IN;
   assign rx_byte  = (mode == MODE_ASYNC10) ? s_reg.rx_sh[8:1] : s_reg.rx_sh[7:0];
   assign rx_ninth = s_reg.rx_sh[8];
   // Only mask bits that are set take part; a zero mask always matches.
   assign addr_match = ((rx_byte ^ s_reg.saddr) & s_reg.mask) == 8'h00;
   always_comb
   begin
      if (mode == MODE_ASYNC10)
      begin
         rx_accept = !(s_reg.sm2 && !rx_stop);
      end
      else
      begin
         rx_accept = !s_reg.sm2 || (rx_ninth && addr_match);
      end
   end

   // ****************************************************************
   // State update.
   // ****************************************************************
   always_comb
   begin
      s_next         = s_reg;
      s_next.rx_prev = RXD_IN;
      // Software writes are applied first so that hardware events win.
      if (SFR_WR && SFR_ADDR == ADDR_MASK)
      begin
         s_next.mask = SFR_WDATA;
      end
      if (SFR_WR && SFR_ADDR == ADDR_STATION)
      begin
         s_next.saddr = SFR_WDATA;
      end
      if (wr_ctl)
      begin
         if (FRAME_ERR_VIEW_SELECT)
         begin
            s_next.fe = SFR_WDATA[CTL_MODE_HI];
         end
         else
         begin
            s_next.mode_hi = SFR_WDATA[CTL_MODE_HI];
         end
         s_next.mode_lo = SFR_WDATA[CTL_MODE_LO];
         s_next.sm2     = SFR_WDATA[CTL_MULTIPROC];
         s_next.ren     = SFR_WDATA[CTL_RX_ENABLE];
         s_next.tb8     = SFR_WDATA[CTL_TX_NINTH];
         s_next.rb8     = SFR_WDATA[CTL_RX_NINTH];
         s_next.ti      = SFR_WDATA[CTL_TX_DONE];
         s_next.ri      = SFR_WDATA[CTL_RX_DONE];
         // A rising receive enable in mode 0 with the transmitter idle starts one clocked receive.
         if (mode == MODE_SYNC && !s_reg.ren && SFR_WDATA[CTL_RX_ENABLE]
             && s_reg.tx_st == TX_IDLE)
         begin
            s_next.rx_st   = RX_SYNC;
            s_next.rx_bits = SYNC_BITS;
            s_next.rx_ph   = 1'b0;
         end
      end

      // Transmitter. A write while a frame is going out is dropped.
      case (s_reg.tx_st)
         TX_IDLE:
         begin
            if (wr_buf)
            begin
               s_next.txact = 1'b1;
               s_next.tx_cnt = 4'h0;
               s_next.tx_ph  = 1'b0;
               if (mode == MODE_SYNC)
               begin
                  s_next.tx_st   = TX_SYNC;
                  s_next.tx_sh   = {3'h7, SFR_WDATA};
                  s_next.tx_bits = SYNC_BITS;
               end
               else if (mode == MODE_ASYNC10)
               begin
                  s_next.tx_st   = TX_ASYNC;
                  s_next.tx_sh   = {2'h3, SFR_WDATA, 1'b0};
                  s_next.tx_bits = TX_BITS_10;
               end
               else
               begin
                  s_next.tx_st   = TX_ASYNC;
                  s_next.tx_sh   = {1'b1, s_reg.tb8, SFR_WDATA, 1'b0};
                  s_next.tx_bits = TX_BITS_11;
               end
            end
         end
         TX_ASYNC:
         begin
            if (tk.sample_tick)
            begin
               s_next.tx_cnt = s_reg.tx_cnt + 4'h1;
               if (s_reg.tx_cnt == LAST_TICK)
               begin
                  s_next.tx_sh   = {1'b1, s_reg.tx_sh[10:1]};
                  s_next.tx_bits = s_reg.tx_bits - 4'h1;
                  if (s_reg.tx_bits == 4'h2)
                  begin
                     s_next.ti    = 1'b1;
                     s_next.txact = 1'b0;
                  end
                  if (s_reg.tx_bits == STOP_LEFT)
                  begin
                     s_next.tx_st = TX_IDLE;
                  end
               end
            end
         end
         TX_SYNC:
         begin
            if (tk.shift_tick)
            begin
               s_next.tx_ph = !s_reg.tx_ph;
               if (s_reg.tx_ph)
               begin
                  s_next.tx_sh   = {1'b1, s_reg.tx_sh[10:1]};
                  s_next.tx_bits = s_reg.tx_bits - 4'h1;
                  if (s_reg.tx_bits == STOP_LEFT)
                  begin
                     s_next.ti    = 1'b1;
                     s_next.txact = 1'b0;
                     s_next.tx_st = TX_IDLE;
                  end
               end
            end
         end
         default:
         begin
            s_next.tx_st = TX_IDLE;
         end
      endcase

      // Receiver.
      case (s_reg.rx_st)
         RX_IDLE:
         begin
            if (s_reg.ren && mode != MODE_SYNC && s_reg.rx_prev && !RXD_IN)
            begin
               s_next.rx_st  = RX_START;
               s_next.rx_cnt = 4'h0;
            end
         end
         RX_START:
         begin
            if (tk.sample_tick)
            begin
               s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
               if (s_reg.rx_cnt == MID_TICK)
               begin
                  // A start bit that is high again at mid-bit was a glitch.
                  s_next.rx_st   = RXD_IN ? RX_IDLE : RX_DATA;
                  s_next.rx_cnt  = 4'h0;
                  s_next.rx_bits = (mode == MODE_ASYNC10) ? RX_BITS_10 : RX_BITS_11;
               end
            end
         end
         RX_DATA:
         begin
            if (tk.sample_tick)
            begin
               s_next.rx_cnt = s_reg.rx_cnt + 4'h1;
               if (s_reg.rx_cnt == LAST_TICK)
               begin
                  s_next.rx_bits = s_reg.rx_bits - 4'h1;
                  s_next.rx_sh   = {RXD_IN, s_reg.rx_sh[8:1]};
               end
            end
            if (rx_fin)
            begin
               s_next.rx_st = RX_IDLE;
               s_next.rx_sh = s_reg.rx_sh;
               if (!rx_stop)
               begin
                  s_next.fe = 1'b1;
               end
               if (rx_accept)
               begin
                  s_next.rbuf = rx_byte;
                  s_next.ri   = 1'b1;
                  if (mode != MODE_ASYNC10)
                  begin
                     s_next.rb8 = rx_ninth;
                  end
                  else if (!s_reg.sm2)
                  begin
                     s_next.rb8 = rx_stop;
                  end
               end
            end
         end
         RX_SYNC:
         begin
            if (tk.shift_tick)
            begin
               s_next.rx_ph = !s_reg.rx_ph;
               if (s_reg.rx_ph)
               begin
                  s_next.rx_sh   = {RXD_IN, s_reg.rx_sh[8:1]};
                  s_next.rx_bits = s_reg.rx_bits - 4'h1;
                  if (s_reg.rx_bits == STOP_LEFT)
                  begin
                     s_next.rbuf  = {RXD_IN, s_reg.rx_sh[8:2]};
                     s_next.ri    = 1'b1;
                     s_next.rx_st = RX_IDLE;
                  end
               end
            end
         end
         default:
         begin
            s_next.rx_st = RX_IDLE;
         end
      endcase
      // The new enable is used, so that the write starting a mode 0 receive is not cut.
      if (!s_next.ren && s_reg.rx_st != RX_SYNC)
      begin
         s_next.rx_st = RX_IDLE;
      end

      // Pin and status outputs, all registered.
      s_next.txd     = 1'b1;
      s_next.rxd_oe  = 1'b0;
      s_next.rxd_out = 1'b1;
      if (s_next.tx_st == TX_ASYNC)
      begin
         s_next.txd = s_next.tx_sh[0];
      end
      else if (s_next.tx_st == TX_SYNC)
      begin
         s_next.txd     = !s_next.tx_ph;
         s_next.rxd_oe  = 1'b1;
         s_next.rxd_out = s_next.tx_sh[0];
      end
      else if (s_next.rx_st == RX_SYNC)
      begin
         s_next.txd = !s_next.rx_ph;
      end
      s_next.irq = PORT1_IRQ_ENABLE && (s_next.ri || s_next.ti);

      // Read data; the control high bit shows the view that is selected.
      case (SFR_ADDR)
         ADDR_MASK:    s_next.rdata = s_reg.mask;
         ADDR_STATION: s_next.rdata = s_reg.saddr;
         ADDR_CONTROL: s_next.rdata = {FRAME_ERR_VIEW_SELECT ? s_reg.fe : s_reg.mode_hi,
                                       s_reg.mode_lo, s_reg.sm2, s_reg.ren, s_reg.tb8,
                                       s_reg.rb8, s_reg.ti, s_reg.ri};
         ADDR_BUFFER:  s_next.rdata = s_reg.rbuf;
         default:      s_next.rdata = UNMAPPED_READ;
      endcase
      if (!SFR_RD)
      begin
         s_next.rdata = s_reg.rdata;
      end
   end

   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         s_reg         <= '0;
         s_reg.txd     <= 1'b1;
         s_reg.rxd_out <= 1'b1;
         s_reg.rx_prev <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign SFR_RDATA          = s_reg.rdata;
   assign TXD                = s_reg.txd;
   assign RXD_OUT            = s_reg.rxd_out;
   assign RXD_OE             = s_reg.rxd_oe;
   assign SERIAL1_IRQ        = s_reg.irq;
   assign TX_ACTIVITY_STATUS = s_reg.txact;

   // ****************************************************************
   // Checks.
   // ****************************************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RESETN);

   sequence s_sync_tx_start;
      wr_buf && mode == MODE_SYNC && s_reg.tx_st == TX_IDLE;
   endsequence
   sequence s_tx_done_seen;
      ##[1:200] s_reg.ti;
   endsequence

   property p_mask_blocks;
      rx_fin && mode != MODE_ASYNC10 && s_reg.sm2 && rx_ninth
      && ((rx_byte ^ s_reg.saddr) & s_reg.mask) != 8'h00 |=> $stable(s_reg.rbuf);
   endproperty
   a_mask_blocks: assert property (p_mask_blocks) else $error("masked mismatch accepted");

   property p_zero_mask;
      rx_fin && mode != MODE_ASYNC10 && s_reg.sm2 && rx_ninth && s_reg.mask == 8'h00
      |=> s_reg.ri && s_reg.rbuf == $past(rx_byte);
   endproperty
   a_zero_mask: assert property (p_zero_mask) else $error("zero mask did not accept");

   property p_ninth_zero;
      rx_fin && mode != MODE_ASYNC10 && s_reg.sm2 && !rx_ninth |=> $stable(s_reg.rbuf);
   endproperty
   a_ninth_zero: assert property (p_ninth_zero) else $error("ninth bit zero accepted");

   property p_bad_stop_m1;
      rx_fin && mode == MODE_ASYNC10 && s_reg.sm2 && !rx_stop |=> $stable(s_reg.rbuf);
   endproperty
   a_bad_stop_m1: assert property (p_bad_stop_m1) else $error("bad stop accepted");

   property p_frame_err;
      rx_fin && !rx_stop |=> s_reg.fe;
   endproperty
   a_frame_err: assert property (p_frame_err) else $error("framing error not flagged");

   property p_mode_kept;
      wr_ctl && FRAME_ERR_VIEW_SELECT |=> s_reg.mode_hi == $past(s_reg.mode_hi);
   endproperty
   a_mode_kept: assert property (p_mode_kept) else $error("mode changed in error view");

   property p_act_clears;
      $rose(s_reg.ti) && $past(s_reg.tx_st) != TX_IDLE |-> !TX_ACTIVITY_STATUS;
   endproperty
   a_act_clears: assert property (p_act_clears) else $error("activity still set");

   property p_irq_masked;
      !PORT1_IRQ_ENABLE |=> !SERIAL1_IRQ;
   endproperty
   a_irq_masked: assert property (p_irq_masked) else $error("interrupt not masked");

   property p_sync_tx_done;
      s_sync_tx_start |-> s_tx_done_seen;
   endproperty
   a_sync_tx_done: assert property (p_sync_tx_done) else $error("mode 0 send never done");

endmodule
`default_nettype wire

// [testbench/spa_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Remote serial node on the line side of the port.
// ****************************************************************
module spa_partner
(
   // Line
   input  wire logic clk,
   input  wire logic txd,
   input  wire logic sdat,
   output var  logic rxd
);
   initial rxd = 1'b1;

   // Bits go out LSB first and the line idles high, so a start bit is a falling edge.
   task automatic send(input logic [10:0] bits, input int nb, input int bclk);
      for (int i = 0; i < nb; i++)
      begin
         rxd = bits[i];
         repeat (bclk) @(negedge clk);
      end
      rxd = 1'b1;
   endtask

   // Samples each bit in its middle, half a bit after the start edge.
   task automatic recv(output logic [10:0] bits, input int nb, input int bclk);
      int n;
      bits = '0;
      n = 0;
      while (txd === 1'b1 && n < 2000)
      begin
         @(negedge clk);
         n++;
      end
      repeat (bclk / 2) @(negedge clk);
      for (int i = 0; i < nb; i++)
      begin
         bits[i] = txd;
         repeat (bclk) @(negedge clk);
      end
   endtask

   // Mode 0 from the port: data stands still while the shift clock is low, so sample there.
   task automatic recv0(output logic [7:0] bits, output int per);
      realtime t0;
      bits = '0;
      per  = 0;
      t0   = 0.0;
      for (int i = 0; i < 8; i++)
      begin
         @(negedge txd);
         if (i == 1)
         begin
            per = int'(($realtime - t0) / 25.0);
         end
         t0 = $realtime;
         @(negedge clk);
         bits[i] = sdat;
      end
   endtask

   // Mode 0 into the port: it samples on the rising shift clock, so change just after it.
   task automatic send0(input logic [7:0] bits);
      for (int i = 0; i < 8; i++)
      begin
         rxd = bits[i];
         @(posedge txd);
         @(negedge clk);
      end
      rxd = 1'b1;
   endtask
endmodule
`default_nettype wire

// [testbench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tb;
   import spa_pkg::*;
   logic        clk = 0, resetn = 0, wr = 0, rd = 0, fev = 0, ien = 0, t1 = 0;
   logic [7:0]  addr = 0, wdata = 0, rdata;
   logic        txd, rxd_in, rxd_out, rxd_oe, irq, act;
   logic [10:0] f;
   int          fails = 0, tests_run = 0;

   always #12.5 clk = ~clk;
   // An overflow every other clock gives 32 clocks per bit in modes 1 and 3.
   always @(negedge clk) t1 <= ~t1;

   spa_serial_port1 i_spa_serial_port1 (.CLK(clk), .RESETN(resetn), .SFR_ADDR(addr),
      .SFR_WR(wr), .SFR_RD(rd), .SFR_WDATA(wdata), .SFR_RDATA(rdata),
      .FRAME_ERR_VIEW_SELECT(fev), .PORT1_IRQ_ENABLE(ien), .T1_OVF(t1), .TXD(txd),
      .RXD_IN(rxd_in), .RXD_OUT(rxd_out), .RXD_OE(rxd_oe), .SERIAL1_IRQ(irq),
      .TX_ACTIVITY_STATUS(act));
   spa_partner i_spa_partner (.clk(clk), .txd(txd), .sdat(rxd_out), .rxd(rxd_in));

   // ****************************************************************
   // Shared tasks.
   // ****************************************************************
   task automatic chk(input string nm, input logic [10:0] seen, input logic [10:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      @(negedge clk);
      wr = 0;
      rd = 0;
      @(negedge clk);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      acc(1'b0, a, 8'h00);
      chk(nm, rdata, exp);
   endtask
   task automatic frame(input logic [7:0] d, input logic b9);
      i_spa_partner.send({1'b1, b9, d, 1'b0}, 11, 32);
      repeat (4) @(negedge clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // ****************************************************************
   // Scenarios.
   // ****************************************************************
   task automatic t_reset;
      rdchk("control", ADDR_CONTROL, RESET_BYTE);
      rdchk("mask", ADDR_MASK, RESET_BYTE);
      rdchk("buffer", ADDR_BUFFER, RESET_BYTE);
      rdchk("unmapped", 8'h55, UNMAPPED_READ);
      chk("pins idle", {txd, rxd_out, rxd_oe, irq, act}, 5'h18);
   endtask
   task automatic t_tx;
      acc(1'b1, ADDR_CONTROL, 8'hc8);
      acc(1'b1, ADDR_BUFFER, 8'ha5);
      chk("activity", act, 1'b1);
      i_spa_partner.recv(f, 11, 32);
      chk("tx frame", f, {1'b1, 1'b1, 8'ha5, 1'b0});
      chk("activity end", act, 1'b0);
      rdchk("tx done", ADDR_CONTROL, 8'hca);
   endtask
   task automatic t_rx3;
      acc(1'b1, ADDR_STATION, 8'h5a);
      acc(1'b1, ADDR_CONTROL, 8'hf0);
      frame(8'h33, 1'b1);
      rdchk("open mask", ADDR_BUFFER, 8'h33);
      rdchk("rx ninth", ADDR_CONTROL, 8'hf5);
      acc(1'b1, ADDR_CONTROL, 8'hf0);
      acc(1'b1, ADDR_MASK, 8'hf0);
      frame(8'h63, 1'b1);
      frame(8'h5c, 1'b0);
      rdchk("rejects", ADDR_CONTROL, 8'hf0);
      rdchk("kept", ADDR_BUFFER, 8'h33);
      frame(8'h5c, 1'b1);
      rdchk("masked match", ADDR_BUFFER, 8'h5c);
      ien = 1;
      repeat (3) @(negedge clk);
      chk("irq on", irq, 1'b1);
      ien = 0;
      repeat (3) @(negedge clk);
      chk("irq off", irq, 1'b0);
      acc(1'b1, ADDR_CONTROL, 8'he0);
      // This byte passes the mask, so only the receive enable can stop it.
      frame(8'h53, 1'b1);
      rdchk("ren off", ADDR_BUFFER, 8'h5c);
      rdchk("ren off ri", ADDR_CONTROL, 8'he0);
   endtask
   task automatic t_fe;
      acc(1'b1, ADDR_CONTROL, 8'h70);
      fev = 1;
      i_spa_partner.send({1'b0, 8'h81, 1'b0}, 10, 32);
      repeat (4) @(negedge clk);
      rdchk("bad stop", ADDR_CONTROL, 8'hf0);
      acc(1'b1, ADDR_CONTROL, 8'hf0);
      fev = 0;
      rdchk("mode kept", ADDR_CONTROL, 8'h70);
      fev = 1;
      acc(1'b1, ADDR_CONTROL, 8'h70);
      rdchk("fe cleared", ADDR_CONTROL, 8'h70);
      fev = 0;
      acc(1'b1, ADDR_CONTROL, 8'h50);
      i_spa_partner.send({1'b1, 8'h81, 1'b0}, 10, 32);
      repeat (4) @(negedge clk);
      rdchk("stop in rb8", ADDR_CONTROL, 8'h55);
      rdchk("mode1 data", ADDR_BUFFER, 8'h81);
   endtask
   task automatic t_m02;
      logic [7:0] b;
      int         per;
      acc(1'b1, ADDR_CONTROL, 8'h00);
      fork
         acc(1'b1, ADDR_BUFFER, 8'h96);
         i_spa_partner.recv0(b, per);
      join
      chk("mode0 oe", rxd_oe, 1'b1);
      chk("mode0 tx", b, 8'h96);
      chk("mode0 period", 11'(per), 11'(MODE0_CLKS_SLOW));
      repeat (8) @(negedge clk);
      chk("mode0 idle", {rxd_oe, rxd_out}, 2'h1);
      rdchk("mode0 done", ADDR_CONTROL, 8'h02);
      acc(1'b1, ADDR_CONTROL, 8'h20);
      fork
         acc(1'b1, ADDR_CONTROL, 8'h30);
         i_spa_partner.send0(8'hc5);
      join
      repeat (4) @(negedge clk);
      rdchk("mode0 rx", ADDR_BUFFER, 8'hc5);
      rdchk("mode0 ri", ADDR_CONTROL, 8'h31);
      acc(1'b1, ADDR_CONTROL, 8'h90);
      i_spa_partner.send({1'b1, 1'b1, 8'ha3, 1'b0}, 11, 64);
      repeat (4) @(negedge clk);
      rdchk("mode2 rx", ADDR_BUFFER, 8'ha3);
      rdchk("mode2 ninth", ADDR_CONTROL, 8'h95);
   endtask

   initial
   begin
      repeat (6) @(negedge clk);
      resetn = 1;
      t_reset;
      t_tx;
      t_rx3;
      t_fe;
      t_m02;
      results;
   end
   initial
   begin
      #(25 * 20000);
      fails++;
      results;
   end
endmodule
`default_nettype wire
